// ==== common/tws_consts.svh ====
// constants of the two-wire slave register port
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// fixed slave address, binary 1100000
`define TWS_SLAVE_ADDR 7'h60
// number of internal registers and the highest subaddress
`define TWS_NUM_REGS 8'h08
`define TWS_TOP_SUB 3'h7
// bits in one byte on the wire
`define TWS_BYTE_BITS 4'h8
// reset value of every internal register
`define TWS_REG_RESET 8'h00

`endif

// ==== common/tws_pkg.sv ====
// types of the two-wire slave register port
package tws_pkg;

  typedef enum logic [3:0] {
    TWS_ST_IDLE      = 4'b0000,
    TWS_ST_ADDR      = 4'b0001,
    TWS_ST_ADDR_ACK  = 4'b0010,
    TWS_ST_SUB       = 4'b0011,
    TWS_ST_SUB_ACK   = 4'b0100,
    TWS_ST_WDATA     = 4'b0101,
    TWS_ST_WDATA_ACK = 4'b0110,
    TWS_ST_RDATA     = 4'b0111,
    TWS_ST_RDATA_ACK = 4'b1000
  } tws_state_e;

  typedef struct packed {
    tws_state_e state;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [2:0] ptr;
    logic rw;
    logic nack;
    logic oe;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
  } tws_ctl_s;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } tws_sync_s;

  typedef struct packed {
    logic [7:0][7:0] regs;
    logic [7:0] rdata;
  } tws_mem_s;

endpackage

// ==== hdl/tws_sync.sv ====
// two-flop synchroniser and line event detector for clock and data
`timescale 1ns/10ps
module tws_sync
  import tws_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin
  output logic sda_o, // synchronised data level
  output logic scl_rise_o, // serial clock rose
  output logic scl_fall_o, // serial clock fell
  output logic start_o, // start condition seen
  output logic stop_o // stop condition seen
);

  tws_sync_s st;
  tws_sync_s next_st;

  // bit 1 is clock, bit 0 is data; meta is read only by sync
  always_comb begin
    next_st = st;
    next_st.meta = {scl_i, sda_i};
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign sda_o = st.sync[0];
  assign scl_rise_o = st.sync[1] & ~st.prev[1];
  assign scl_fall_o = ~st.sync[1] & st.prev[1];
  assign start_o = st.sync[1] & st.prev[1] & st.prev[0] & ~st.sync[0];
  assign stop_o = st.sync[1] & st.prev[1] & ~st.prev[0] & st.sync[0];

endmodule // tws_sync

// ==== hdl/tws_regmem.sv ====
// eight internal configuration registers with registered read port
`timescale 1ns/10ps
module tws_regmem
  import tws_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic we_i, // write strobe
  input wire logic [2:0] waddr_i, // write subaddress
  input wire logic [7:0] wdata_i, // write data
  input wire logic [2:0] raddr_i, // read subaddress
  output logic [7:0] rdata_o, // read data, registered
  output logic [63:0] regs_o // all register contents
);

  `include "tws_consts.svh"

  tws_mem_s st;
  tws_mem_s next_st;

  always_comb begin
    next_st = st;
    if (we_i) begin
      next_st.regs[waddr_i] = wdata_i;
    end
    next_st.rdata = st.regs[raddr_i];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st.regs <= {8{`TWS_REG_RESET}};
      st.rdata <= `TWS_REG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flat
      assign regs_o[gi*8 +: 8] = st.regs[gi];
    end
  endgenerate

endmodule // tws_regmem

// ==== hdl/tws_slave.sv ====
// two-wire slave port reaching eight internal configuration registers
`timescale 1ns/10ps
//
// Behaviour
// - answer only fixed address 1100000
// - address lsb one reads, zero writes
// - start is data fall, clock high
// - shift eight address bits, msb first
// - acknowledge own address on ninth pulse
// - foreign address: release bus, stay idle
// - second byte of a write is starting subaddress
// - subaddress increments after each data byte, holding at the highest
// - single registers accessible on their own
// - stray stop forces idle, stray start reopens address phase
// - invalid subaddress: no acknowledge, idle
// - reads past top repeat highest register
module tws_slave
  import tws_pkg::*;
(
  input wire logic clk_sys_i, // system clock, 40 MHz
  input wire logic rst_i, // async reset, active high
  input wire logic scl_i, // serial clock from master
  input wire logic serial_data_line_i, // data line level
  output logic serial_data_line_o, // data line drive value, always low
  output logic serial_data_line_oe_o, // high while pulling data low
  output logic [63:0] cfg_regs_o, // register contents, reg n at [8n+7:8n]
  output logic reg_wr_o, // pulse: a register was written
  output logic [2:0] reg_wr_addr_o, // subaddress of that write
  output logic [7:0] reg_wr_data_o, // data of that write
  output logic busy_o // a transfer is in progress
);

  `include "tws_consts.svh"

  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic [7:0] rdata;

  tws_ctl_s st;
  tws_ctl_s next_st;

  tws_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(serial_data_line_i),
    .sda_o(sda),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start),
    .stop_o(stop)
  );

  tws_regmem u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .we_i(st.wr_en),
    .waddr_i(st.wr_addr),
    .wdata_i(st.wr_data),
    .raddr_i(st.ptr),
    .rdata_o(rdata),
    .regs_o(cfg_regs_o)
  );

  // a complete byte has been clocked in or out
  function automatic logic byte_full(input logic [3:0] cnt);
    byte_full = (cnt == `TWS_BYTE_BITS);
  endfunction

  // next subaddress, held at the highest register
  function automatic logic [2:0] sat_inc(input logic [2:0] p);
    sat_inc = (p == `TWS_TOP_SUB) ? p : 3'(p + 3'h1);
  endfunction

  always_comb begin
    next_st = st;
    next_st.wr_en = 1'b0;
    if (stop) begin
      // end of transfer, from any state
      next_st.state = TWS_ST_IDLE;
      next_st.oe = 1'b0;
      next_st.bitcnt = 4'h0;
    end else if (start) begin
      // a start always reopens the address phase; stop then start in
      // one clock high period arrive as two separate events
      next_st.state = TWS_ST_ADDR;
      next_st.oe = 1'b0;
      next_st.bitcnt = 4'h0;
      next_st.nack = 1'b0;
    end else begin
      case (st.state)
        TWS_ST_IDLE: begin
          next_st.oe = 1'b0;
        end
        TWS_ST_ADDR: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda};
            next_st.bitcnt = 4'(st.bitcnt + 4'h1);
          end else if (scl_fall && byte_full(st.bitcnt)) begin
            next_st.bitcnt = 4'h0;
            if (st.shift[7:1] == `TWS_SLAVE_ADDR) begin
              next_st.rw = st.shift[0];
              next_st.oe = 1'b1;
              next_st.state = TWS_ST_ADDR_ACK;
            end else begin
              next_st.oe = 1'b0;
              next_st.state = TWS_ST_IDLE;
            end
          end
        end
        TWS_ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_st.bitcnt = 4'h0;
            if (st.rw) begin
              // read starts at the subaddress pointer as left by the last write or read
              next_st.shift = rdata;
              next_st.oe = ~rdata[7];
              next_st.state = TWS_ST_RDATA;
            end else begin
              next_st.oe = 1'b0;
              next_st.state = TWS_ST_SUB;
            end
          end
        end
        TWS_ST_SUB: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda};
            next_st.bitcnt = 4'(st.bitcnt + 4'h1);
          end else if (scl_fall && byte_full(st.bitcnt)) begin
            next_st.bitcnt = 4'h0;
            if (st.shift < `TWS_NUM_REGS) begin
              next_st.ptr = st.shift[2:0];
              next_st.oe = 1'b1;
              next_st.state = TWS_ST_SUB_ACK;
            end else begin
              next_st.oe = 1'b0;
              next_st.state = TWS_ST_IDLE;
            end
          end
        end
        TWS_ST_SUB_ACK: begin
          if (scl_fall) begin
            next_st.oe = 1'b0;
            next_st.bitcnt = 4'h0;
            next_st.state = TWS_ST_WDATA;
          end
        end
        TWS_ST_WDATA: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda};
            next_st.bitcnt = 4'(st.bitcnt + 4'h1);
          end else if (scl_fall && byte_full(st.bitcnt)) begin
            next_st.bitcnt = 4'h0;
            // only the addressed register changes
            next_st.wr_en = 1'b1;
            next_st.wr_addr = st.ptr;
            next_st.wr_data = st.shift;
            next_st.ptr = sat_inc(st.ptr);
            next_st.oe = 1'b1;
            next_st.state = TWS_ST_WDATA_ACK;
          end
        end
        TWS_ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_st.oe = 1'b0;
            next_st.bitcnt = 4'h0;
            next_st.state = TWS_ST_WDATA;
          end
        end
        TWS_ST_RDATA: begin
          if (scl_rise) begin
            next_st.bitcnt = 4'(st.bitcnt + 4'h1);
          end else if (scl_fall) begin
            if (byte_full(st.bitcnt)) begin
              next_st.bitcnt = 4'h0;
              next_st.oe = 1'b0;
              next_st.ptr = sat_inc(st.ptr);
              next_st.nack = 1'b0;
              next_st.state = TWS_ST_RDATA_ACK;
            end else begin
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.oe = ~st.shift[6];
            end
          end
        end
        TWS_ST_RDATA_ACK: begin
          if (scl_rise) begin
            next_st.nack = sda;
          end else if (scl_fall) begin
            next_st.bitcnt = 4'h0;
            if (st.nack) begin
              next_st.oe = 1'b0;
              next_st.state = TWS_ST_IDLE;
            end else begin
              next_st.shift = rdata;
              next_st.oe = ~rdata[7];
              next_st.state = TWS_ST_RDATA;
            end
          end
        end
        default: begin
          next_st.oe = 1'b0;
          next_st.state = TWS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign serial_data_line_o = 1'b0;
  assign serial_data_line_oe_o = st.oe;
  assign reg_wr_o = st.wr_en;
  assign reg_wr_addr_o = st.wr_addr;
  assign reg_wr_data_o = st.wr_data;
  assign busy_o = (st.state != TWS_ST_IDLE);

endmodule // tws_slave

// ==== verification/tws_master.sv ====
// two-wire bus master model driving the clock and pulling data low
`timescale 1ns/10ps
module tws_master (
  output logic scl_o, // serial clock, high outside frames
  output logic sda_oe_o, // high while pulling data low
  input wire logic sda_i // resolved data wire
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // long low phase lets the slave let go of an ack first
  task automatic start();
    sda_oe_o = 1'b0;
    #120 scl_o = 1'b1;
    #60 sda_oe_o = 1'b1;
    #60 scl_o = 1'b0;
  endtask
  // clock stays low long enough for the slave to drop its ack first
  task automatic stop();
    sda_oe_o = 1'b1;
    #120 scl_o = 1'b1;
    #60 sda_oe_o = 1'b0;
    #100;
  endtask
  // 140 ns low, 60 ns high, wire sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    #20 sda_oe_o = !b;
    #120 scl_o = 1'b1;
    #40 r = sda_i;
    #20 scl_o = 1'b0;
  endtask
  // msb first, then the ninth pulse; a one releases the line
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r[i]);
    end
    bitx(a, ak);
  endtask
endmodule // tws_master

// ==== verification/tws_slave_chk.sv ====
// assertions on the two-wire slave port pins
`timescale 1ns/10ps
module tws_slave_chk (
  input wire logic clk_sys_i, // clock
  input wire logic rst_i, // reset
  input wire logic scl_i, // serial clock
  input wire logic serial_data_line_i, // data wire
  input wire logic serial_data_line_o, // drive value
  input wire logic serial_data_line_oe_o, // pull low
  input wire logic [63:0] cfg_regs_o, // registers
  input wire logic reg_wr_o, // write pulse
  input wire logic [2:0] reg_wr_addr_o, // write sub
  input wire logic [7:0] reg_wr_data_o, // write data
  input wire logic busy_o // busy
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_drv; serial_data_line_o == 1'b0; endproperty
  a_drv: assert property (p_drv) else $error("drive value not low");
  property p_start; $fell(serial_data_line_i) && scl_i |-> ##[1:6] busy_o; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop; $rose(serial_data_line_i) && scl_i |-> ##[1:6] !busy_o; endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_quiet; !busy_o && !$past(busy_o) |-> !serial_data_line_oe_o; endproperty
  a_quiet: assert property (p_quiet) else $error("line pulled while idle");
  property p_oe_low; $changed(serial_data_line_oe_o) |-> !scl_i; endproperty
  a_oe_low: assert property (p_oe_low) else $error("drive moved with clock high");
  property p_oe_hold; $rose(serial_data_line_oe_o) |=> serial_data_line_oe_o [*3]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
  property p_pulse; reg_wr_o |=> !reg_wr_o; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse too long");
  property p_store; reg_wr_o |=> cfg_regs_o[{reg_wr_addr_o, 3'b000} +: 8] == reg_wr_data_o; endproperty
  a_store: assert property (p_store) else $error("write not stored");
  property p_wr_busy; reg_wr_o |-> busy_o && !scl_i; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write outside transfer");
endmodule // tws_slave_chk
bind tws_slave tws_slave_chk u_chk (.clk_sys_i, .rst_i, .scl_i, .serial_data_line_i, .serial_data_line_o,
  .serial_data_line_oe_o, .cfg_regs_o, .reg_wr_o, .reg_wr_addr_o, .reg_wr_data_o, .busy_o);

// ==== verification/two_wire_slave_register_port_test.sv ====
// self-checking bench for the two-wire slave register port
`timescale 1ns/10ps
module two_wire_slave_register_port_test;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl, m_oe, oe, wr, busy, ak;
  logic [63:0] cfg;
  logic [63:0] exp_cfg = '0;
  logic [7:0] r;
  int n_mismatch = 0;
  int check_count = 0;
  int n_wr = 0;
  int cyc = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  // open-drain wire with pull-up
  wire sda = !(m_oe || oe);
  tws_master m (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
  tws_slave dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .serial_data_line_i(sda),
    .serial_data_line_o(), .serial_data_line_oe_o(oe), .cfg_regs_o(cfg), .reg_wr_o(wr),
    .reg_wr_addr_o(), .reg_wr_data_o(), .busy_o(busy));
  // sampled away from the launching edge
  always @(negedge clk_sys_i) begin
    if (wr === 1'b1) n_wr++;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic tx(input logic [7:0] b, input logic a);
    m.xfer(b, 1'b1, r, ak);
    chk("ack", a, !ak);
  endtask
  task automatic rx(input logic [7:0] e, input logic more);
    m.xfer(8'hFF, !more, r, ak);
    chk("read data", e, r);
  endtask
  task automatic settle(input int w);
    repeat (8) @(negedge clk_sys_i);
    chk("busy", 0, busy);
    chk("registers", exp_cfg, cfg);
    chk("write pulses", w, n_wr);
    n_wr = 0;
  endtask
  task automatic t_write();
    m.start();
    tx(8'hC0, 1);
    tx(8'h02, 1);
    tx(8'hA5, 1);
    tx(8'h5A, 1);
    tx(8'h3C, 1);
    m.stop();
    exp_cfg[39:16] = 24'h3C5AA5;
    settle(3);
    m.start();
    tx(8'hC0, 1);
    tx(8'h06, 1);
    tx(8'h81, 1);
    m.stop();
    exp_cfg[55:48] = 8'h81;
    settle(1);
  endtask
  task automatic t_read();
    m.start();
    tx(8'hC0, 1);
    tx(8'h03, 1);
    m.start();
    tx(8'hC1, 1);
    rx(8'h5A, 1);
    rx(8'h3C, 0);
    m.stop();
    settle(0);
  endtask
  task automatic t_top();
    m.start();
    tx(8'hC0, 1);
    tx(8'h07, 1);
    tx(8'h11, 1);
    tx(8'h22, 1);
    m.stop();
    exp_cfg[63:56] = 8'h22;
    settle(2);
    m.start();
    tx(8'hC0, 1);
    tx(8'h06, 1);
    m.start();
    tx(8'hC1, 1);
    rx(8'h81, 1);
    rx(8'h22, 1);
    rx(8'h22, 1);
    rx(8'h22, 0);
    m.stop();
    settle(0);
  endtask
  task automatic t_refuse();
    logic [7:0] bad [5] = '{8'hC2, 8'h40, 8'hE0, 8'hC8, 8'hC0};
    for (int i = 0; i < 5; i++) begin
      m.start();
      if (i == 4) tx(8'hC0, 1);
      tx(i == 4 ? 8'h08 : bad[i], 0);
      chk("busy", 0, busy);
      tx(8'h01, 0);
      m.stop();
      settle(0);
    end
  endtask
  task automatic t_abort();
    m.start();
    tx(8'hC0, 1);
    tx(8'h01, 1);
    repeat (4) m.bitx(1'b0, ak);
    m.stop();
    settle(0);
    m.start();
    tx(8'hC0, 1);
    repeat (3) m.bitx(1'b1, ak);
    m.start();
    tx(8'hC0, 1);
    tx(8'h01, 1);
    tx(8'h99, 1);
    m.stop();
    exp_cfg[15:8] = 8'h99;
    settle(1);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk("reset registers", 0, cfg);
    t_write();
    t_read();
    t_top();
    t_refuse();
    t_abort();
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule // two_wire_slave_register_port_test
